//--- inc/bupw_cfg.svh
// Offsets, field positions and reset values of the prefetch and I/O window registers
`ifndef BUPW_CFG_SVH
`define BUPW_CFG_SVH

// Configuration offsets, byte addresses
`define BUPW_OFF_PF_BOTTOM 8'h24
`define BUPW_OFF_PF_TOP 8'h26
`define BUPW_OFF_PF_BOTTOM_HIGH 8'h28
`define BUPW_OFF_PF_TOP_HIGH 8'h2C
`define BUPW_OFF_IO_BOTTOM_HIGH 8'h30
`define BUPW_OFF_IO_TOP_HIGH 8'h32

// Field positions inside the 16-bit window registers and their 32-bit dword images
`define BUPW_WIN_FIELD_MSB 15
`define BUPW_WIN_FIELD_LSB 4
`define BUPW_WIDE_IND_MSB 3
`define BUPW_TOP_FIELD_MSB 31
`define BUPW_TOP_FIELD_LSB 20
`define BUPW_HALF_LO_MSB 15
`define BUPW_HALF_LO_LSB 0
`define BUPW_HALF_HI_MSB 31
`define BUPW_HALF_HI_LSB 16

// Idle read data and the zero pad that widens the I/O probe
`define BUPW_RDATA_IDLE 32'h00000000
`define BUPW_IO_PAD 4'h0

// Read-only wide address indicator and reset values
`define BUPW_WIDE_IND 4'h1
`define BUPW_RST_PF_TOP 16'h0001
`define BUPW_RST_FIELD 12'h000
`define BUPW_RST_HIGH32 32'h00000000
`define BUPW_RST_HIGH16 16'h0000

// Implied low address bits under each field
`define BUPW_LOW_ZEROS 20'h00000
`define BUPW_LOW_ONES 20'hFFFFF

// Writable bit masks: one for the 24h dword, one with all bits writable for the 28h, 2Ch and 30h dwords
`define BUPW_MASK_PF 32'hFFF0FFF0
`define BUPW_MASK_ALL 32'hFFFFFFFF

`endif

//--- inc/bupw_pkg.sv
// Types used by the window register bank
`default_nettype none
package bupw_pkg;
  typedef logic [63:0] bupw_mem_addr_t;
  typedef logic [35:0] bupw_io_addr_t;
  typedef logic [31:0] bupw_dword_t;
  typedef logic [11:0] bupw_field_t;
  typedef logic [7:0] bupw_cfg_addr_t;
endpackage : bupw_pkg
`default_nettype wire

//--- inc/bupw_win_if.sv
// Window bounds and probe address carried from the register bank to a comparator
`timescale 1ns/1ps
`default_nettype none
interface bupw_win_if #(parameter int W = 64);
  logic [W-1:0] bottom;
  logic [W-1:0] top;
  logic [W-1:0] addr;
  logic in_range;
  modport cmp (input bottom, input top, input addr, output in_range);
  modport user (output bottom, output top, output addr, input in_range);
endinterface : bupw_win_if
`default_nettype wire

//--- rtl/bupw_window_cmp.sv
// Registered inclusive range check of one address against one window
`timescale 1ns/1ps
`default_nettype none
module bupw_window_cmp (
  input wire logic clk,
  input wire logic srst,
  bupw_win_if.cmp win
);
  logic at_or_above;
  logic at_or_below;
  logic next_inside;

  // Both bounds inclusive; a bottom above the top gives an empty window
  assign at_or_above = (win.addr >= win.bottom);
  assign at_or_below = (win.addr <= win.top);
  assign next_inside = at_or_above && at_or_below;

  // Registered so the verdict is a clean flop output one cycle after the address
  always_ff @(posedge clk) begin
    if (srst) begin
      win.in_range <= 1'b0;
    end else begin
      win.in_range <= next_inside;
    end
  end
endmodule : bupw_window_cmp
`default_nettype wire

//--- rtl/bupw_regs.sv
// Prefetchable and I/O window configuration registers with forwarding decisions
//
// Operation
// (R1) Limit field bits 15:4 hold address 31:20
// (R2) Limit low 20 address bits read as ones
// (R3) Limit bits 3:0 read-only 1, wide address
// (R4) Limit address 63:32 from register 2Ch
// (R5) Base upper 32 bits at 28h, reset zero
// (R6) Limit upper 32 bits, reset zero
// (R7) I/O base upper 16 bits at 30h
// (R8) I/O base low 20 bits are zeros
// (R9) Prefetch window decides memory forwarding
// (R10) Base field bits 15:4 at 24h, low zeros
// (R11) I/O top upper 16 bits at 32h, ones below
// (R12) Inside when base <= address <= limit
//
// Software reaches the bank through a one-cycle strobe interface. Every
// answer is registered, so read data and claim follow the strobe by one
// clock; the window bounds are plain wiring from the stored fields.
`timescale 1ns/1ps
`default_nettype none
`include "bupw_cfg.svh"
module bupw_regs (
  input wire logic clk,
  input wire logic srst,
  // Configuration space access, dword aligned with byte enables
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  output logic cfg_claim,
  // Forwarding probes from the datapath on this clock
  input wire logic [63:0] mem_addr,
  input wire logic [31:0] io_addr,
  output logic mem_in_window,
  output logic io_in_window,
  // Assembled window bounds for the forwarding logic
  output logic [63:0] pf_window_bottom,
  output logic [63:0] pf_window_top,
  output logic [35:0] io_window_bottom,
  output logic [35:0] io_window_top
);
  // Four dword images cover the six registers of the bank
  localparam int NDW = 4;

  // Stored fields
  bupw_pkg::bupw_field_t prefetch_bottom_field;
  bupw_pkg::bupw_field_t prefetch_top_field;
  bupw_pkg::bupw_dword_t prefetch_window_bottom_high;
  bupw_pkg::bupw_dword_t prefetch_window_top_high;
  logic [15:0] io_window_bottom_high;
  logic [15:0] io_top_field;

  // Dword views of the register map, in the order 24h, 28h, 2Ch, 30h
  bupw_pkg::bupw_dword_t cur_dw [NDW];
  bupw_pkg::bupw_dword_t mask_dw [NDW];
  bupw_pkg::bupw_dword_t next_dw [NDW];
  bupw_pkg::bupw_cfg_addr_t off_dw [NDW];
  logic [NDW-1:0] hit_dw;
  logic [NDW-1:0] wr_dw;
  logic [15:0] prefetch_window_top;
  logic [15:0] prefetch_window_bottom;
  logic [31:0] next_rdata;
  logic any_hit;
  logic any_access;
  logic next_rvalid;
  logic next_claim;
  logic [31:0] next_cfg_rdata;
  logic [35:0] io_probe;

  // Next stored values, cut from the merged dword images
  bupw_pkg::bupw_field_t next_bottom_field;
  bupw_pkg::bupw_field_t next_top_field;
  bupw_pkg::bupw_dword_t next_bottom_high;
  bupw_pkg::bupw_dword_t next_top_high;
  logic [15:0] next_io_bottom_high;
  logic [15:0] next_io_top;

  // Whole 16-bit registers as software sees them; low nibble is read-only
  assign prefetch_window_bottom = {prefetch_bottom_field, `BUPW_WIDE_IND}; // R10
  assign prefetch_window_top = {prefetch_top_field, `BUPW_WIDE_IND}; // R3

  // Dword images: 24h pairs base and limit, 30h pairs I/O base and top
  assign cur_dw[0] = {prefetch_window_top, prefetch_window_bottom}; // R1
  assign cur_dw[1] = prefetch_window_bottom_high;
  assign cur_dw[2] = prefetch_window_top_high;
  assign cur_dw[3] = {io_top_field, io_window_bottom_high};

  // Only the field bits are writable; the indicators ignore writes
  assign mask_dw[0] = `BUPW_MASK_PF; // R3
  assign mask_dw[1] = `BUPW_MASK_ALL;
  assign mask_dw[2] = `BUPW_MASK_ALL;
  assign mask_dw[3] = `BUPW_MASK_ALL;

  // Dword base offsets; the odd 16-bit offsets live in the upper half
  assign off_dw[0] = `BUPW_OFF_PF_BOTTOM;
  assign off_dw[1] = `BUPW_OFF_PF_BOTTOM_HIGH;
  assign off_dw[2] = `BUPW_OFF_PF_TOP_HIGH;
  assign off_dw[3] = `BUPW_OFF_IO_BOTTOM_HIGH;

  // Decode and byte-lane merge, one entry per dword and lane
  for (genvar r = 0; r < NDW; r++) begin : g_dw
    assign hit_dw[r] = (cfg_addr[7:2] == off_dw[r][7:2]);
    assign wr_dw[r] = cfg_wr && hit_dw[r];
    for (genvar b = 0; b < 4; b++) begin : g_lane
      logic [7:0] merged;
      logic lane_wr;
      // Read-only bits keep their stored value even inside an enabled lane
      assign merged = (cfg_wdata[b*8 +: 8] & mask_dw[r][b*8 +: 8])
        | (cur_dw[r][b*8 +: 8] & ~mask_dw[r][b*8 +: 8]);
      assign lane_wr = wr_dw[r] && cfg_be[b];
      assign next_dw[r][b*8 +: 8] = lane_wr ? merged : cur_dw[r][b*8 +: 8];
    end
  end

  // Field cuts; the indicator nibbles at 3:0 and 19:16 are never stored
  assign next_bottom_field = next_dw[0][`BUPW_WIN_FIELD_MSB:`BUPW_WIN_FIELD_LSB]; // R10
  assign next_top_field = next_dw[0][`BUPW_TOP_FIELD_MSB:`BUPW_TOP_FIELD_LSB]; // R1
  assign next_bottom_high = next_dw[1]; // R5
  assign next_top_high = next_dw[2]; // R6
  assign next_io_bottom_high = next_dw[3][`BUPW_HALF_LO_MSB:`BUPW_HALF_LO_LSB]; // R7
  assign next_io_top = next_dw[3][`BUPW_HALF_HI_MSB:`BUPW_HALF_HI_LSB]; // R11

  // Prefetch base and limit fields; partial byte writes update only enabled lanes
  always_ff @(posedge clk) begin
    if (srst) begin
      prefetch_bottom_field <= `BUPW_RST_FIELD; // R10
      prefetch_top_field <= `BUPW_RST_FIELD; // R1
    end else begin
      prefetch_bottom_field <= next_bottom_field; // R10
      prefetch_top_field <= next_top_field; // R1
    end
  end

  // Upper 32 bits of the prefetch window bounds
  always_ff @(posedge clk) begin
    if (srst) begin
      prefetch_window_bottom_high <= `BUPW_RST_HIGH32; // R5
      prefetch_window_top_high <= `BUPW_RST_HIGH32; // R6
    end else begin
      prefetch_window_bottom_high <= next_bottom_high; // R5
      prefetch_window_top_high <= next_top_high; // R6
    end
  end

  // Upper 16 bits of the I/O window bounds
  always_ff @(posedge clk) begin
    if (srst) begin
      io_window_bottom_high <= `BUPW_RST_HIGH16; // R7
      io_top_field <= `BUPW_RST_HIGH16; // R11
    end else begin
      io_window_bottom_high <= next_io_bottom_high; // R7
      io_top_field <= next_io_top; // R11
    end
  end

  // Read selection; offsets outside this bank read as zero and are not claimed
  assign any_hit = |hit_dw;
  assign next_rdata = hit_dw[0] ? cur_dw[0]
                    : hit_dw[1] ? cur_dw[1]
                    : hit_dw[2] ? cur_dw[2]
                    : hit_dw[3] ? cur_dw[3]
                    : `BUPW_RDATA_IDLE;

  // Response decode; read data is held at zero outside a read answer
  assign any_access = cfg_rd || cfg_wr;
  assign next_rvalid = cfg_rd;
  assign next_claim = any_access && any_hit;
  assign next_cfg_rdata = cfg_rd ? next_rdata : `BUPW_RDATA_IDLE;

  // Read data comes from a flop, one cycle after the strobe; read has no side effect
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_rdata <= `BUPW_RDATA_IDLE;
      cfg_rvalid <= 1'b0;
      cfg_claim <= 1'b0;
    end else begin
      cfg_rdata <= next_cfg_rdata;
      cfg_rvalid <= next_rvalid;
      cfg_claim <= next_claim;
    end
  end

  // Window assembly: implied low bits fill below each 20-bit-aligned field
  assign pf_window_bottom = {prefetch_window_bottom_high, prefetch_bottom_field, `BUPW_LOW_ZEROS}; // R10
  assign pf_window_top = {prefetch_window_top_high, prefetch_top_field, `BUPW_LOW_ONES}; // R2 R4
  assign io_window_bottom = {io_window_bottom_high, `BUPW_LOW_ZEROS}; // R8
  assign io_window_top = {io_top_field, `BUPW_LOW_ONES}; // R11

  // Comparator links; the I/O probe is widened with zeros to the 36-bit range
  bupw_win_if #(.W(64)) mem_win ();
  bupw_win_if #(.W(36)) io_win ();

  // Memory side carries the full 64-bit probe
  assign mem_win.bottom = pf_window_bottom;
  assign mem_win.top = pf_window_top;
  assign mem_win.addr = mem_addr;

  // I/O side; a 32-bit probe can never reach bounds above bit 31
  assign io_probe = {`BUPW_IO_PAD, io_addr};
  assign io_win.bottom = io_window_bottom;
  assign io_win.top = io_window_top;
  assign io_win.addr = io_probe;

  // Memory forwarding decision against the full 64-bit prefetch window
  bupw_window_cmp u_mem_cmp ( // R9 R12
    .clk(clk),
    .srst(srst),
    .win(mem_win.cmp)
  );

  // I/O forwarding decision; one registered stage, like the memory check
  bupw_window_cmp u_io_cmp (
    .clk(clk),
    .srst(srst),
    .win(io_win.cmp)
  );

  // Flags pass straight out of the comparator flops
  assign mem_in_window = mem_win.in_range; // R9
  assign io_in_window = io_win.in_range;
endmodule : bupw_regs
`default_nettype wire

//--- test/bupw_regs_sva.sv
// Assertion checker for the window register bank
`timescale 1ns/1ps
`default_nettype none
module bupw_regs_sva (
  input wire logic clk,
  input wire logic srst,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rvalid,
  input wire logic [63:0] mem_addr,
  input wire logic [31:0] io_addr,
  input wire logic mem_in_window,
  input wire logic io_in_window,
  input wire logic [63:0] pf_window_bottom,
  input wire logic [63:0] pf_window_top,
  input wire logic [35:0] io_window_bottom,
  input wire logic [35:0] io_window_top
);
  // Last dword read; a write in the same cycle lands after the read, so those are skipped
  logic [5:0] dw;
  logic ok;
  always_ff @(posedge clk) begin
    dw <= cfg_addr[7:2];
    ok <= cfg_rd && !cfg_wr && !srst;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_rv; !$past(srst) |-> cfg_rvalid == $past(cfg_rd); endproperty
  property p_d24; ok && dw == 6'h09 |-> cfg_rdata == {pf_window_top[31:20], 4'h1, pf_window_bottom[31:20], 4'h1};
  endproperty
  property p_d28; ok && dw == 6'h0A |-> cfg_rdata == pf_window_bottom[63:32]; endproperty
  property p_d2c; ok && dw == 6'h0B |-> cfg_rdata == pf_window_top[63:32]; endproperty
  property p_d30; ok && dw == 6'h0C |-> cfg_rdata == {io_window_top[35:20], io_window_bottom[35:20]}; endproperty
  property p_low; pf_window_top[19:0] == 20'hFFFFF && io_window_top[19:0] == 20'hFFFFF
    && pf_window_bottom[19:0] == 20'h00000 && io_window_bottom[19:0] == 20'h00000; endproperty
  property p_mem; !$past(srst) |-> mem_in_window == ($past(mem_addr) >= $past(pf_window_bottom)
    && $past(mem_addr) <= $past(pf_window_top)); endproperty
  property p_io; !$past(srst) |-> io_in_window == ({4'h0, $past(io_addr)} >= $past(io_window_bottom)
    && {4'h0, $past(io_addr)} <= $past(io_window_top)); endproperty
  a_rv: assert property (p_rv) else $error("read answer not one cycle after request");
  a_d24: assert property (p_d24) else $error("window dword readback wrong");
  a_d28: assert property (p_d28) else $error("bottom high readback wrong");
  a_d2c: assert property (p_d2c) else $error("top high readback wrong");
  a_d30: assert property (p_d30) else $error("io dword readback wrong");
  a_low: assert property (p_low) else $error("implied low bits wrong");
  a_mem: assert property (p_mem) else $error("memory window flag wrong");
  a_io: assert property (p_io) else $error("io window flag wrong");
  // Main scenarios reached
  c_rd: cover property (ok && dw == 6'h09);
  c_mem: cover property (mem_in_window);
  c_io: cover property (io_in_window);
endmodule : bupw_regs_sva
bind bupw_regs bupw_regs_sva bupw_regs_sva_inst (.clk, .srst, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_rdata, .cfg_rvalid,
  .mem_addr, .io_addr, .mem_in_window, .io_in_window, .pf_window_bottom, .pf_window_top, .io_window_bottom,
  .io_window_top);
`default_nettype wire

//--- test/tb_bupw_regs.sv
// Self-checking bench for the window register bank
`timescale 1ns/1ps
`default_nettype none
module tb_bupw_regs;
  logic clk, srst, cfg_wr, cfg_rd, cfg_rvalid, cfg_claim, mem_in_window, io_in_window;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, io_addr;
  logic [63:0] mem_addr, pf_window_bottom, pf_window_top;
  logic [35:0] io_window_bottom, io_window_top;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  bupw_regs bupw_regs_inst (.clk, .srst, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_rvalid,
    .cfg_claim, .mem_addr, .io_addr, .mem_in_window, .io_in_window, .pf_window_bottom, .pf_window_top,
    .io_window_bottom, .io_window_top);
  // Clock and hang guard; a run of under a hundred cycles is expected
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic chk(input logic [65:0] got, input logic [65:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Strobes last one cycle; answer is looked at one cycle after the request
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge clk);
    {cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b1, a, be, d};
    @(negedge clk);
    cfg_wr = 1'b0;
    chk({cfg_rvalid, cfg_claim}, {1'b0, a inside {8'h24, 8'h28, 8'h2C, 8'h30}});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(negedge clk);
    {cfg_rd, cfg_addr} = {1'b1, a};
    @(negedge clk);
    cfg_rd = 1'b0;
    chk({cfg_rvalid, cfg_claim, cfg_rdata}, {1'b1, a inside {8'h24, 8'h28, 8'h2C, 8'h30}, exp});
  endtask : rd
  task automatic pr(input logic [63:0] m, input logic [31:0] i, input logic [1:0] exp);
    @(negedge clk);
    {mem_addr, io_addr} = {m, i};
    @(negedge clk);
    chk({mem_in_window, io_in_window}, exp);
  endtask : pr
  task automatic t_reset;
    srst = 1'b1;
    repeat (4) @(negedge clk);
    srst = 1'b0;
    rd(8'h24, 32'h00010001);
    rd(8'h28, 32'h00000000);
    rd(8'h2C, 32'h00000000);
    rd(8'h30, 32'h00000000);
    chk(pf_window_top, 64'h00000000000FFFFF);
    $display("test reset done");
  endtask : t_reset
  task automatic t_regs;
    wr(8'h24, 4'hF, 32'hFFFFFFFF);
    rd(8'h24, 32'hFFF1FFF1);
    wr(8'h24, 4'h5, 32'h00000000);
    rd(8'h24, 32'hFF01FF01);
    wr(8'h28, 4'hF, 32'h12345678);
    wr(8'h2C, 4'hF, 32'h12345679);
    wr(8'h30, 4'hF, 32'hABCD1234);
    wr(8'h24, 4'hF, 32'h20001000);
    rd(8'h2C, 32'h12345679);
    chk(pf_window_bottom, 64'h1234567810000000);
    chk(pf_window_top, 64'h12345679200FFFFF);
    chk(io_window_bottom, 36'h123400000);
    chk(io_window_top, 36'hABCDFFFFF);
    wr(8'h34, 4'hF, 32'hFFFFFFFF);
    rd(8'h34, 32'h00000000);
    $display("test registers done");
  endtask : t_regs
  // Probes on both sides of each bound
  task automatic t_window;
    wr(8'h30, 4'hF, 32'h00020001);
    pr(64'h123456780FFFFFFF, 32'h000FFFFF, 2'b00);
    pr(64'h1234567810000000, 32'h00100000, 2'b11);
    pr(64'h12345679200FFFFF, 32'h002FFFFF, 2'b11);
    pr(64'h1234567920100000, 32'h00300000, 2'b00);
    $display("test window done");
  endtask : t_window
  // Write and read in one cycle return the old value; a read right behind sees the new one
  task automatic t_order;
    @(negedge clk);
    {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = {2'b11, 8'h28, 4'hF, 32'h0F0E0001};
    @(negedge clk);
    {cfg_wr, cfg_rd} = 2'b01;
    chk({cfg_rvalid, cfg_claim, cfg_rdata}, {2'b11, 32'h12345678});
    @(negedge clk);
    cfg_rd = 1'b0;
    chk({cfg_rvalid, cfg_claim, cfg_rdata}, {2'b11, 32'h0F0E0001});
    @(negedge clk);
    chk({cfg_rvalid, cfg_claim, cfg_rdata}, 34'h000000000);
    $display("test order done");
  endtask : t_order
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out
  initial begin
    {srst, cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata, mem_addr, io_addr} = {1'b1, 142'h0};
    t_reset();
    t_regs();
    t_window();
    t_order();
    t_reset();
    close_out();
  end
endmodule : tb_bupw_regs
`default_nettype wire
